// ==== verilog/ucsb_pkg.sv ====
// Constants for the serial channel control, status, break and wake-up block.
// Assumes an 8-bit register port with byte offsets and one 10 MHz clock.
package ucsb_pkg;
   localparam logic [7:0] ADDR_CTRL2 = 8'hBA;
   localparam logic [7:0] ADDR_CTRL3 = 8'hBB;
   localparam logic [7:0] ADDR_STAT2 = 8'hBC;
   localparam logic [7:0] ADDR_DATA = 8'hBD;
   localparam logic [7:0] ADDR_ICLR = 8'hC2;
   localparam logic [7:0] RST_CTRL2 = 8'h00;
   localparam logic [7:0] RST_CTRL3 = 8'h00;
   localparam logic [7:0] RST_STAT2 = 8'h00;
   localparam logic [7:0] RST_DATA = 8'hFF;
   // Control register two fields.
   localparam int C2_TXE_IE = 7;
   localparam int C2_TC_IE = 6;
   localparam int C2_RXF_IE = 5;
   localparam int C2_LINE_QUIET_IRQ_EN = 4;
   localparam int C2_TX_ON = 3;
   localparam int C2_RX_ON = 2;
   localparam int C2_RWU = 1;
   localparam int C2_BRK = 0;
   // Control register three fields.
   localparam int C3_R8 = 7;
   localparam int C3_T8 = 6;
   localparam int C3_TXDIR = 5;
   localparam int C3_TXINV = 4;
   localparam int C3_RXINV = 3;
   localparam int C3_RWUIDLE = 2;
   localparam int C3_IDLESEL = 1;
   localparam int C3_WAKESEL = 0;
   // Status register two fields.
   localparam int S2_BRK_IF = 7;
   localparam int S2_EDGE_IF = 6;
   localparam int S2_ACTIVE = 5;
   localparam int S2_BRK_IE = 3;
   localparam int S2_EDGE_IE = 2;
   localparam int S2_BRKLEN = 1;
   localparam int S2_BRKDET_EN = 0;
   // Flag order in the clear register and the flag vector.
   localparam int F_TXE = 7;
   localparam int F_TC = 6;
   localparam int F_RXF = 5;
   localparam int F_IDLE = 4;
   localparam int F_OVR = 3;
   localparam int F_NOISE = 2;
   localparam int F_FRAME = 1;
   localparam int F_PAR = 0;
   // Character lengths in bit times.
   localparam logic [3:0] BITS_IDLE = 4'd10;
   localparam logic [3:0] BITS_BRK_SHORT = 4'd10;
   localparam logic [3:0] BITS_BRK_LONG = 4'd13;
   localparam logic [3:0] BITS_BRK_DET = 4'd11;
   localparam logic [3:0] BITS_FRAME = 4'd10;
   localparam int CLK_HZ = 10000000;
   localparam int BAUD_DEFAULT = 9600;
   typedef enum logic [1:0] {TX_IDLE, TX_SHIFT, TX_BREAK} ucsb_tx_e;
   typedef enum logic [1:0] {RX_IDLE, RX_SHIFT, RX_STOP} ucsb_rx_e;
endpackage

// ==== verilog/ucsb_top.sv ====
// Serial channel control block: registers, transmitter, receiver, break and wake-up.
// Assumes synchronous inputs, a one-cycle register port and a 16x oversampling rate.
//
// Our own choice: strobed register access.
`timescale 1ns/100ps
`default_nettype none
module ucsb_top #(
   parameter int BAUD = ucsb_pkg::BAUD_DEFAULT
) (
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic [7:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [7:0] rdata_out,
   input wire logic data_mode_in,
   input wire logic stop_mode_in,
   input wire logic single_wire_in,
   input wire logic rxd_in,
   input wire logic txd_in,
   output logic txd_out,
   output logic txd_oe_out,
   output logic [5:0] irq_req_out
);
   import ucsb_pkg::*;

   localparam logic [15:0] DIV = 16'(CLK_HZ / (BAUD * 16));

   // Extra bit times for the ninth data bit and the second stop bit.
   function automatic logic [3:0] len_adj(input logic [3:0] base, input logic d, input logic s);
      len_adj = base + {3'd0, d} + {3'd0, s};
   endfunction

   logic [7:0] c2_q, c3_q, s2_q, rxbuf_q, txbuf_q;
   logic [7:0] flags_q;
   logic brk_armed_q, brk_pend_q, txbuf_full_q;
   logic [15:0] div_q;
   logic tick;
   logic wr_c2, wr_c3, wr_s2, wr_d, wr_clr;
   logic rx_raw, rx_in_sel;
   logic rx_prev_q;
   ucsb_tx_e tx_st_q;
   ucsb_rx_e rx_st_q;
   logic [3:0] tx_os_q, tx_bit_q, rx_os_q, rx_bit_q;
   logic [9:0] tx_sh_q;
   logic [8:0] rx_sh_q;
   logic tx_line_q;
   logic [7:0] low_bits_q, idle_bits_q;
   logic idle_arm_q, brk_seen_q;
   logic ev_txe, ev_tc, ev_rxf, ev_idle, ev_ovr, ev_frame, ev_brk, ev_edge;
   logic wake_hit;

   assign wr_c2 = wr_in && addr_in == ADDR_CTRL2;
   assign wr_c3 = wr_in && addr_in == ADDR_CTRL3;
   assign wr_s2 = wr_in && addr_in == ADDR_STAT2;
   assign wr_d = wr_in && addr_in == ADDR_DATA;
   assign wr_clr = wr_in && addr_in == ADDR_ICLR;

   // Oversampling tick at sixteen times the bit rate.
   always_ff @(posedge ref_clk_in) begin
      if (rst_in || div_q == DIV - 16'd1) begin
         div_q <= 16'h0000;
      end else begin
         div_q <= div_q + 16'h0001;
      end
   end
   assign tick = div_q == DIV - 16'd1;

   // Receive source: own pin or the shared pin in single-wire input mode.
   assign rx_raw = (single_wire_in && !c3_q[C3_TXDIR]) ? txd_in : rxd_in;
   assign rx_in_sel = rx_raw ^ c3_q[C3_RXINV];

   // Control register two, with the write-one-then-zero break sequence.
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         c2_q <= RST_CTRL2;
         brk_armed_q <= 1'b0;
      end else begin
         if (wr_c2) begin
            c2_q <= wdata_in;
            brk_armed_q <= wdata_in[C2_BRK];
         end
         if (wake_hit) begin
            c2_q[C2_RWU] <= 1'b0;
         end
      end
   end

   // Break request queued on the falling write of the break bit.
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         brk_pend_q <= 1'b0;
      end else if (wr_c2 && brk_armed_q && !wdata_in[C2_BRK]) begin
         brk_pend_q <= 1'b1;
      end else if (tx_st_q == TX_BREAK) begin
         brk_pend_q <= 1'b0;
      end
   end

   // Control register three; the ninth received bit is hardware-owned.
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         c3_q <= RST_CTRL3;
      end else begin
         if (wr_c3) begin
            c3_q[6:0] <= wdata_in[6:0];
         end
         if (ev_rxf) begin
            c3_q[C3_R8] <= rx_sh_q[8];
         end
      end
   end

   // Status two: sticky flags set wins over a write-one clear.
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         s2_q <= RST_STAT2;
      end else begin
         if (wr_s2) begin
            s2_q[3:0] <= wdata_in[3:0];
            if (wdata_in[S2_BRK_IF]) s2_q[S2_BRK_IF] <= 1'b0;
            if (wdata_in[S2_EDGE_IF]) s2_q[S2_EDGE_IF] <= 1'b0;
         end
         if (ev_brk) s2_q[S2_BRK_IF] <= 1'b1;
         if (ev_edge) s2_q[S2_EDGE_IF] <= 1'b1;
         s2_q[S2_ACTIVE] <= rx_st_q != RX_IDLE;
      end
   end

   // Channel event flags, cleared by writing one in the clear register.
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         flags_q <= 8'h00;
      end else begin
         if (wr_clr) begin
            flags_q <= flags_q & ~wdata_in;
         end
         if (ev_txe) flags_q[F_TXE] <= 1'b1;
         if (ev_tc) flags_q[F_TC] <= 1'b1;
         if (ev_rxf) flags_q[F_RXF] <= 1'b1;
         if (ev_idle) flags_q[F_IDLE] <= 1'b1;
         if (ev_ovr) flags_q[F_OVR] <= 1'b1;
         if (ev_frame) flags_q[F_FRAME] <= 1'b1;
      end
   end

   // Transmit buffer written through the data register.
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         txbuf_q <= RST_DATA;
         txbuf_full_q <= 1'b0;
      end else if (wr_d) begin
         txbuf_q <= wdata_in;
         txbuf_full_q <= 1'b1;
      end else if (ev_txe) begin
         txbuf_full_q <= 1'b0;
      end
   end

   assign ev_txe = tx_st_q == TX_IDLE && txbuf_full_q && c2_q[C2_TX_ON] && !brk_pend_q;

   // Transmitter: frames and breaks, idle high while switched on.
   always_ff @(posedge ref_clk_in) begin
      if (rst_in || !c2_q[C2_TX_ON]) begin
         tx_st_q <= TX_IDLE;
         tx_os_q <= 4'd0;
         tx_bit_q <= 4'd0;
         tx_sh_q <= 10'h3FF;
         tx_line_q <= 1'b1;
      end else begin
         unique case (tx_st_q)
            TX_IDLE: begin
               tx_line_q <= 1'b1;
               tx_os_q <= 4'd0;
               if (brk_pend_q) begin
                  tx_st_q <= TX_BREAK;
                  tx_line_q <= 1'b0;
                  tx_bit_q <= len_adj(s2_q[S2_BRKLEN] ? BITS_BRK_LONG : BITS_BRK_SHORT,
                     data_mode_in, stop_mode_in);
               end else if (ev_txe) begin
                  tx_st_q <= TX_SHIFT;
                  tx_line_q <= 1'b0;
                  tx_sh_q <= {1'b1, c3_q[C3_T8], txbuf_q};
                  tx_bit_q <= len_adj(BITS_FRAME - 4'd1, data_mode_in, stop_mode_in);
               end
            end
            TX_SHIFT: begin
               if (tick) begin
                  tx_os_q <= tx_os_q + 4'd1;
                  if (tx_os_q == 4'd15) begin
                     if (tx_bit_q == 4'd0) begin
                        tx_st_q <= TX_IDLE;
                        tx_line_q <= 1'b1;
                     end else begin
                        tx_bit_q <= tx_bit_q - 4'd1;
                        tx_line_q <= tx_sh_q[0];
                        // Eight-bit frames drop the ninth bit and refill with stop level.
                        tx_sh_q <= data_mode_in ? {1'b1, tx_sh_q[9:1]}
                           : {3'b111, tx_sh_q[7:1]};
                     end
                  end
               end
            end
            TX_BREAK: begin
               if (tick) begin
                  tx_os_q <= tx_os_q + 4'd1;
                  if (tx_os_q == 4'd15) begin
                     tx_bit_q <= tx_bit_q - 4'd1;
                     if (tx_bit_q == 4'd1) begin
                        tx_st_q <= TX_IDLE;
                        tx_line_q <= 1'b1;
                     end
                  end
               end
            end
            default: tx_st_q <= TX_IDLE;
         endcase
      end
   end

   assign ev_tc = tx_st_q == TX_SHIFT && tick && tx_os_q == 4'd15 && tx_bit_q == 4'd0;

   // Pin drive: inversion and single-wire direction.
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         txd_out <= 1'b1;
         txd_oe_out <= 1'b0;
      end else begin
         txd_out <= tx_line_q ^ c3_q[C3_TXINV];
         txd_oe_out <= c2_q[C2_TX_ON] && (!single_wire_in || c3_q[C3_TXDIR]);
      end
   end

   // Receiver: start detect, sampling in the first tick of each data bit, stop check.
   always_ff @(posedge ref_clk_in) begin
      if (rst_in || !c2_q[C2_RX_ON]) begin
         rx_st_q <= RX_IDLE;
         rx_os_q <= 4'd0;
         rx_bit_q <= 4'd0;
         rx_sh_q <= 9'h000;
      end else if (tick) begin
         unique case (rx_st_q)
            RX_IDLE: begin
               // Free-running phase so the idle and break counters see one sample a bit.
               rx_os_q <= rx_os_q + 4'd1;
               if (!rx_in_sel) begin
                  rx_st_q <= RX_SHIFT;
                  rx_bit_q <= data_mode_in ? 4'd9 : 4'd8;
                  rx_os_q <= 4'd8;
               end
            end
            RX_SHIFT: begin
               rx_os_q <= rx_os_q + 4'd1;
               if (rx_os_q == 4'd7) begin
                  if (rx_bit_q == 4'd0) begin
                     rx_st_q <= RX_STOP;
                  end else begin
                     rx_bit_q <= rx_bit_q - 4'd1;
                     rx_sh_q <= data_mode_in ? {rx_in_sel, rx_sh_q[8:1]}
                        : {1'b0, rx_in_sel, rx_sh_q[7:1]};
                  end
               end
            end
            RX_STOP: begin
               rx_st_q <= RX_IDLE;
            end
            default: rx_st_q <= RX_IDLE;
         endcase
      end
   end

   // Stop-bit result: data hand-off, overflow and framing error.
   logic rx_done;
   assign rx_done = tick && rx_st_q == RX_STOP;
   assign ev_rxf = rx_done && rx_in_sel && !c2_q[C2_RWU] && c2_q[C2_RX_ON];
   assign ev_frame = rx_done && !rx_in_sel && !c2_q[C2_RWU];
   assign ev_ovr = ev_rxf && flags_q[F_RXF];

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         rxbuf_q <= RST_DATA;
      end else if (ev_rxf && !flags_q[F_RXF]) begin
         rxbuf_q <= rx_sh_q[7:0];
      end
   end

   // Idle-line and break counters measured in bit times.
   always_ff @(posedge ref_clk_in) begin
      if (rst_in || !c2_q[C2_RX_ON]) begin
         rx_prev_q <= 1'b1;
         low_bits_q <= 8'd0;
         idle_bits_q <= 8'd0;
         idle_arm_q <= 1'b0;
         brk_seen_q <= 1'b0;
      end else begin
         rx_prev_q <= rx_in_sel;
         if (rx_st_q == RX_IDLE && !rx_in_sel && rx_prev_q) begin
            idle_arm_q <= !c3_q[C3_IDLESEL];
         end
         if (rx_done) idle_arm_q <= 1'b1;
         if (tick && rx_os_q == 4'd7) begin
            low_bits_q <= rx_in_sel ? 8'd0 : low_bits_q + 8'd1;
            idle_bits_q <= (rx_in_sel && idle_arm_q) ? idle_bits_q + 8'd1 : 8'd0;
         end
         if (rx_in_sel) brk_seen_q <= 1'b0;
         if (ev_brk) brk_seen_q <= 1'b1;
         if (ev_idle || wake_hit) idle_arm_q <= 1'b0;
      end
   end

   assign ev_brk = s2_q[S2_BRKDET_EN] && !brk_seen_q &&
      low_bits_q == {4'd0, len_adj(BITS_BRK_DET, data_mode_in, stop_mode_in)};
   logic idle_full;
   assign idle_full = idle_arm_q &&
      idle_bits_q == {4'd0, len_adj(BITS_IDLE, data_mode_in, stop_mode_in)};
   assign ev_idle = idle_full && (!c2_q[C2_RWU] || c3_q[C3_RWUIDLE]);
   assign ev_edge = c2_q[C2_RX_ON] && rx_prev_q && !rx_in_sel;
   // Wake-up by address mark or by idle line.
   assign wake_hit = c2_q[C2_RWU] && (c3_q[C3_WAKESEL] ?
      (rx_done && rx_in_sel && (data_mode_in ? rx_sh_q[8] : rx_sh_q[7])) : idle_full);

   // Interrupt requests gated by their enables.
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         irq_req_out <= 6'h00;
      end else begin
         irq_req_out[5] <= flags_q[F_TXE] && c2_q[C2_TXE_IE];
         irq_req_out[4] <= flags_q[F_TC] && c2_q[C2_TC_IE];
         irq_req_out[3] <= flags_q[F_RXF] && c2_q[C2_RXF_IE];
         irq_req_out[2] <= flags_q[F_IDLE] && c2_q[C2_LINE_QUIET_IRQ_EN];
         irq_req_out[1] <= s2_q[S2_BRK_IF] && s2_q[S2_BRK_IE];
         irq_req_out[0] <= s2_q[S2_EDGE_IF] && s2_q[S2_EDGE_IE];
      end
   end

   // Read data one cycle after the strobe; unmapped reads return zero.
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         rdata_out <= 8'h00;
      end else if (rd_in) begin
         unique case (addr_in)
            ADDR_CTRL2: rdata_out <= c2_q;
            ADDR_CTRL3: rdata_out <= c3_q;
            ADDR_STAT2: rdata_out <= s2_q & 8'hEF;
            ADDR_DATA: rdata_out <= rxbuf_q;
            ADDR_ICLR: rdata_out <= flags_q;
            default: rdata_out <= 8'h00;
         endcase
      end else begin
         rdata_out <= 8'h00;
      end
   end

   chk_irq_gate: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      irq_req_out[5] |-> $past(c2_q[C2_TXE_IE])) else $error("irq without enable");
   chk_tx_off_idle: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      !c2_q[C2_TX_ON] |=> tx_st_q == TX_IDLE) else $error("tx runs while off");
   chk_rx_off_idle: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      !c2_q[C2_RX_ON] |=> rx_st_q == RX_IDLE) else $error("rx runs while off");
   chk_brk_queue: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      wr_c2 && brk_armed_q && !wdata_in[0] |=> brk_pend_q) else $error("break not queued");
   chk_txd_invert: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      ##1 txd_out == ($past(tx_line_q) ^ $past(c3_q[C3_TXINV]))) else $error("tx polarity");
   chk_oe_dir: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      single_wire_in && !c3_q[C3_TXDIR] |=> !txd_oe_out) else $error("drives as input");
   chk_brk_flag: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      ev_brk |=> s2_q[S2_BRK_IF]) else $error("break flag lost");
   chk_clr_flag: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      wr_clr && wdata_in[F_TXE] && !ev_txe |=> !flags_q[F_TXE]) else $error("clear failed");
   chk_edge_irq: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      irq_req_out[0] |-> $past(s2_q[S2_EDGE_IE])) else $error("edge irq ungated");
   cov_break_sent: cover property (@(posedge ref_clk_in) tx_st_q == TX_BREAK);
   cov_char_rx: cover property (@(posedge ref_clk_in) ev_rxf);
   cov_wake: cover property (@(posedge ref_clk_in) wake_hit);
endmodule
`default_nettype wire

// ==== testbench/ucsb_remote_model.sv ====
// Far-end serial transceiver model: sends characters and breaks, decodes what it hears.
// Assumes eight data bits, one stop bit, idle-high line and BIT_CYC clocks per bit.
`timescale 1ns/100ps
`default_nettype none
module ucsb_remote_model #(
   parameter int BIT_CYC = 16
) (
   input wire logic clk_in,
   input wire logic line_in,
   output logic line_out,
   output logic got_out,
   output logic [7:0] byte_out
);
   int k;
   // The line rests at its idle high level between characters.
   initial begin
      line_out = 1'b1;
      got_out = 1'b0;
      byte_out = 8'hFF;
   end
   // Sends a start bit, eight data bits low bit first, then a stop bit.
   task automatic send_byte(input logic [7:0] b);
      @(posedge clk_in) line_out <= 1'b0;
      repeat (BIT_CYC) @(posedge clk_in);
      for (int j = 0; j < 8; j++) begin
         line_out <= b[j];
         repeat (BIT_CYC) @(posedge clk_in);
      end
      line_out <= 1'b1;
      repeat (BIT_CYC) @(posedge clk_in);
   endtask
   // Holds the line low for n clocks, as a break does.
   task automatic send_low(input int n);
      @(posedge clk_in) line_out <= 1'b0;
      repeat (n) @(posedge clk_in);
      line_out <= 1'b1;
   endtask
   // Decodes each character heard, sampling in the middle of every data bit.
   always begin
      @(negedge line_in);
      repeat (BIT_CYC / 2) @(posedge clk_in);
      for (k = 0; k < 8; k++) begin
         repeat (BIT_CYC) @(posedge clk_in);
         byte_out[k] <= line_in;
      end
      repeat (BIT_CYC) @(posedge clk_in);
      got_out <= 1'b1;
      @(posedge clk_in) got_out <= 1'b0;
   end
endmodule
`default_nettype wire

// ==== testbench/tb_uart_control_status_block.sv ====
// Self-checking bench for the serial control block and its far-end model.
// Assumes sixteen clocks per bit, so the design runs with a fast bit rate.
`timescale 1ns/100ps
`default_nettype none
module tb_uart_control_status_block;
   import ucsb_pkg::*;
   localparam int BAUD_SIM = 625000;
   localparam int BIT_CYC = CLK_HZ / BAUD_SIM;
   logic ref_clk_in = 1'b0, rst_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0, rd_q = 1'b0;
   logic [7:0] addr_in = 8'h00, wdata_in = 8'h00, rdata_out, heard, b;
   logic rxd, txd_out, txd_oe_out, got;
   logic sw = 1'b0, stp = 1'b0, dm = 1'b0;
   logic [5:0] irq_req_out;
   logic [7:0] exp_q[$], exp_tx_q[$];
   logic [31:0] seed = 32'd69;
   int n_errors = 0, samples_checked = 0, t, cnt;
   ucsb_top #(.BAUD(BAUD_SIM)) dut_u (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
      .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
      .rdata_out(rdata_out), .data_mode_in(dm), .stop_mode_in(stp),
      .single_wire_in(sw), .rxd_in(rxd), .txd_in(rxd), .txd_out(txd_out),
      .txd_oe_out(txd_oe_out), .irq_req_out(irq_req_out));
   ucsb_remote_model #(.BIT_CYC(BIT_CYC)) far_u (.clk_in(ref_clk_in), .line_in(txd_out),
      .line_out(rxd), .got_out(got), .byte_out(heard));
   // Free-running system clock.
   initial forever #50 ref_clk_in = ~ref_clk_in;
   // Pseudo-random bytes from an xorshift generator.
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   task automatic check(input logic [7:0] got_v, input logic [7:0] exp_v);
      samples_checked++;
      if (got_v !== exp_v) begin
         n_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got_v, exp_v);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge ref_clk_in) wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge ref_clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      exp_q.push_back(e);
      @(posedge ref_clk_in) rd_in <= 1'b0;
   endtask
   // Compares one interrupt line after the write that changed its cause has landed.
   task automatic ck_irq(input int i, input logic v);
      repeat (3) @(negedge ref_clk_in);
      check({7'h00, irq_req_out[i]}, {7'h00, v});
   endtask
   task automatic wait_irq(input int i);
      t = 0;
      while (irq_req_out[i] !== 1'b1 && t < 3000) begin
         @(negedge ref_clk_in);
         t++;
      end
      if (t == 3000) begin
         check(8'h00, 8'h01);
         end_sim();
      end
   endtask
   // Read data stand only in the cycle after the strobe; decoded bytes as they arrive.
   always @(posedge ref_clk_in) begin
      rd_q <= rd_in;
      if (rd_q) check(rdata_out, exp_q.pop_front());
      if (got && exp_tx_q.size() > 0) check(heard, exp_tx_q.pop_front());
   end
   // Main sequence.
   initial begin
      repeat (6) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      rd(ADDR_CTRL2, RST_CTRL2);
      rd(ADDR_CTRL3, RST_CTRL3);
      rd(ADDR_STAT2, RST_STAT2);
      rd(ADDR_DATA, RST_DATA);
      rd(8'h10, 8'h00);
      wr(8'hB9, 8'hFF);
      rd(ADDR_CTRL2, 8'h00);
      wr(ADDR_CTRL3, 8'hFF);
      rd(ADDR_CTRL3, 8'h7F);
      wr(ADDR_CTRL3, 8'h00);
      wr(ADDR_STAT2, 8'hFF);
      rd(ADDR_STAT2, 8'h0F);
      wr(ADDR_STAT2, 8'h00);
      wr(ADDR_ICLR, 8'hFF);
      wr(ADDR_CTRL2, 8'hF2);
      rd(ADDR_CTRL2, 8'hF2);
      wr(ADDR_CTRL2, 8'h00);
      wr(ADDR_CTRL3, 8'h10);
      repeat (3) @(negedge ref_clk_in);
      check({6'h00, txd_oe_out, txd_out}, 8'h00);
      wr(ADDR_CTRL3, 8'h00);
      repeat (200) @(posedge ref_clk_in);
      // Transmit a byte and watch both transmit flags reach the request lines.
      wr(ADDR_CTRL2, 8'hC8);
      b = rnd();
      exp_tx_q.push_back(b);
      wr(ADDR_DATA, b);
      check({7'h00, txd_oe_out}, 8'h01);
      repeat (200) @(posedge ref_clk_in);
      ck_irq(5, 1'b1);
      ck_irq(4, 1'b1);
      wr(ADDR_ICLR, 8'hC0);
      ck_irq(5, 1'b0);
      ck_irq(4, 1'b0);
      wr(ADDR_CTRL2, 8'h08);
      // Single-wire mode: the shared pin drives only while the direction bit is set.
      sw <= 1'b1;
      repeat (3) @(negedge ref_clk_in);
      check({7'h00, txd_oe_out}, 8'h00);
      wr(ADDR_CTRL3, 8'h20);
      repeat (3) @(negedge ref_clk_in);
      check({7'h00, txd_oe_out}, 8'h01);
      wr(ADDR_CTRL3, 8'h00);
      sw <= 1'b0;
      // Short, long, extra-stop and ninth-bit breaks, each queued by writing one then zero.
      for (int i = 0; i < 4; i++) begin
         wr(ADDR_STAT2, (i == 1) ? 8'h02 : 8'h00);
         stp <= i == 2;
         dm <= i == 3;
         wr(ADDR_CTRL2, 8'h09);
         wr(ADDR_CTRL2, 8'h08);
         t = 0;
         while (txd_out !== 1'b0 && t < 100) begin
            @(negedge ref_clk_in);
            t++;
         end
         cnt = 0;
         while (txd_out === 1'b0 && cnt < 400) begin
            @(negedge ref_clk_in);
            cnt++;
         end
         if (t == 100 || cnt == 400) begin
            check(8'h00, 8'h01);
            end_sim();
         end
         check(cnt[7:0], 8'((i == 1 ? BITS_BRK_LONG : BITS_BRK_SHORT) * BIT_CYC
            + (i > 1 ? BIT_CYC : 0)));
      end
      // Receive a byte, mask its request, clear the flag, then unmask the request.
      wr(ADDR_STAT2, 8'h00);
      dm <= 1'b0;
      wr(ADDR_CTRL2, 8'h2C);
      b = rnd();
      far_u.send_byte(b);
      wait_irq(3);
      wr(ADDR_CTRL2, 8'h0C);
      ck_irq(3, 1'b0);
      rd(ADDR_DATA, b);
      wr(ADDR_ICLR, 8'h20);
      wr(ADDR_CTRL2, 8'h2C);
      ck_irq(3, 1'b0);
      wr(ADDR_CTRL2, 8'h28);
      far_u.send_byte(rnd());
      ck_irq(3, 1'b0);
      // A long low on the receive pin is seen as a break, and its flag clears on a one.
      wr(ADDR_CTRL2, 8'h0C);
      wr(ADDR_STAT2, 8'h09);
      far_u.send_low(12 * BIT_CYC);
      repeat (200) @(posedge ref_clk_in);
      ck_irq(1, 1'b1);
      rd(ADDR_STAT2, 8'hC9);
      wr(ADDR_STAT2, 8'hC5);
      rd(ADDR_STAT2, 8'h05);
      ck_irq(1, 1'b0);
      far_u.send_byte(rnd());
      ck_irq(0, 1'b1);
      wr(ADDR_STAT2, 8'h44);
      ck_irq(0, 1'b0);
      // Address-mark wake-up: a plain byte keeps standby, a marked byte ends it.
      wr(ADDR_ICLR, 8'hFF);
      wr(ADDR_CTRL3, 8'h01);
      wr(ADDR_CTRL2, 8'h2E);
      far_u.send_byte(rnd() & 8'h7F);
      rd(ADDR_CTRL2, 8'h2E);
      ck_irq(3, 1'b0);
      far_u.send_byte(rnd() | 8'h80);
      rd(ADDR_CTRL2, 8'h2C);
      repeat (4) @(posedge ref_clk_in);
      if (exp_q.size() + exp_tx_q.size() != 0) check(8'h00, 8'h01);
      end_sim();
   end
endmodule
`default_nettype wire
